// *** inc/tbpm_cfg.svh ***
// register offsets, field positions and reset values of the two-bit port block
`ifndef TBPM_CFG_SVH
`define TBPM_CFG_SVH
`define TBPM_ADDR_OUT      8'h40
`define TBPM_ADDR_IN       8'h41
`define TBPM_ADDR_MODE     8'h70
`define TBPM_OUT_DATA_LSB  0
`define TBPM_OUT_DIR_LSB   2
`define TBPM_MODE_REFOUT   0
`define TBPM_MODE_REFIN    1
`define TBPM_MODE_FOFF     2
`define TBPM_MODE_FON      3
`define TBPM_DIR_RST       2'b11
`define TBPM_DATA_RST      2'b00
`define TBPM_MODE_RST      4'h0
`define TBPM_FUSE_ADDR_RST 5'h00
`endif

// *** inc/tbpm_pkg.sv ***
// types shared by the two-bit port block
package tbpm_pkg;
    typedef logic [7:0] tbpm_addr_t;
    typedef logic [7:0] tbpm_byte_t;
    typedef enum logic [1:0] {
        TBPM_PUMP_AUTO = 2'b00,
        TBPM_PUMP_OFF  = 2'b01,
        TBPM_PUMP_ON   = 2'b11
    } tbpm_pump_t;
endpackage

// *** inc/tbpm_pin_if.sv ***
// per-pin control bundle between the port top and its pad cells
`timescale 1ns/1ps
interface tbpm_pin_if;
    logic dir;
    logic data;
    logic ref_sel;
    logic pad_out;
    logic pad_oe_n;
    modport ctrl (output dir, output data, output ref_sel, input pad_out, input pad_oe_n);
    modport pad  (input dir, input data, input ref_sel, output pad_out, output pad_oe_n);
endinterface

// *** src/tbpm_pad.sv ***
// one port pin cell: direction, data and reference bypass
`timescale 1ns/1ps
module tbpm_pad (
    input  wire logic clk,
    input  wire logic rst_n,
    tbpm_pin_if.pad   pin
);
    logic oe_n_d;
    logic oe_n_q;
    logic out_d;
    logic out_q;

    always_comb begin
        // reference role releases the pad entirely
        oe_n_d = ~(pin.dir & ~pin.ref_sel); // [RULE2] [RULE3] [RULE10]
        out_d  = pin.data & ~pin.ref_sel;   // [RULE8]
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            oe_n_q <= 1'b0;
            out_q  <= 1'b0;
        end else begin
            oe_n_q <= oe_n_d;
            out_q  <= out_d;
        end
    end

    assign pin.pad_out  = out_q;
    assign pin.pad_oe_n = oe_n_q;
endmodule

// *** src/tbpm_port.sv ***
// two-bit port with direction, readback, reference roles and pump forcing
// Notes on behaviour
// [RULE1] each pin's direction is set by its own bit of the output register at 0x40
// [RULE2] direction 1 enables both input and output buffers
// [RULE3] direction 0 makes the pin input only, driver released
// [RULE4] reset sets both direction bits to 1
// [RULE5] pin levels read back from a read-only register at 0x41
// [RULE6] input reads are raw, no debounce or filter
// [RULE7] input buffer stays live on driven pins, showing real level
// [RULE8] pins drive the low data bits of the output register when direction is 1
// [RULE9] output data bits reset low
// [RULE10] reference select bits at 0x70 bypass the pin's digital role
// [RULE11] each pin chooses reference or digital role independently
// [RULE12] force-disable holds pump off, battery tied to pump output
// [RULE13] force-enable keeps pump on and beats force-disable
// [RULE14] slave address bits 1:0 come from the pins, upper bits from fuses
// [RULE15] direction bits sit above data bits; unused bits read zero
`timescale 1ns/1ps
`include "tbpm_cfg.svh"
module tbpm_port (
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    input  wire tbpm_pkg::tbpm_addr_t reg_addr,
    input  wire tbpm_pkg::tbpm_byte_t reg_wdata,
    output      tbpm_pkg::tbpm_byte_t reg_rdata,
    input  wire logic [4:0]        fuse_addr,
    input  wire logic              port_pin_zero_in,
    input  wire logic              port_pin_one_in,
    output      logic              port_pin_zero_out,
    output      logic              port_pin_zero_oe_n,
    output      logic              port_pin_one_out,
    output      logic              port_pin_one_oe_n,
    output      logic              reference_drive_out_en,
    output      logic              reference_take_in_en,
    output      logic              pump_enable,
    output      logic              pump_bypass_to_battery,
    output      logic [6:0]        slave_addr
);
    import tbpm_pkg::*;

    logic [1:0]  dir_q,  dir_d;
    logic [1:0]  data_q, data_d;
    logic [3:0]  mode_q, mode_d;
    logic [1:0]  pin_in;
    tbpm_byte_t  rdata_q, rdata_d;
    logic        pump_en_q, pump_en_d;
    logic        pump_byp_q, pump_byp_d;
    logic [1:0]  ref_q,      ref_d;
    logic [6:0]  saddr_q, saddr_d;
    logic        addr_taken_q, addr_taken_d;
    tbpm_pump_t  pump_mode;

    tbpm_pin_if pin0 ();
    tbpm_pin_if pin1 ();

    // pad inputs are buffered whatever the direction, so readback shows the real level
    assign pin_in = {port_pin_one_in, port_pin_zero_in}; // [RULE7]

    function automatic tbpm_pump_t pump_decode(input logic [3:0] m);
        if (m[`TBPM_MODE_FON])
            pump_decode = TBPM_PUMP_ON;  // [RULE13]
        else if (m[`TBPM_MODE_FOFF])
            pump_decode = TBPM_PUMP_OFF; // [RULE12]
        else
            pump_decode = TBPM_PUMP_AUTO;
    endfunction

    assign pump_mode = pump_decode(mode_q);

    always_comb begin
        dir_d  = dir_q;
        data_d = data_q;
        mode_d = mode_q;
        if (reg_wr) begin
            case (reg_addr)
                `TBPM_ADDR_OUT: begin
                    dir_d  = reg_wdata[`TBPM_OUT_DIR_LSB +: 2];  // [RULE1] [RULE15]
                    data_d = reg_wdata[`TBPM_OUT_DATA_LSB +: 2];
                end
                `TBPM_ADDR_MODE: begin
                    mode_d = reg_wdata[3:0]; // [RULE11]
                end
                default: begin
                    mode_d = mode_q;
                end
            endcase
        end
    end

    always_comb begin
        rdata_d = rdata_q;
        if (reg_rd) begin
            case (reg_addr)
                `TBPM_ADDR_OUT:  rdata_d = {4'h0, dir_q, data_q}; // [RULE15]
                `TBPM_ADDR_IN:   rdata_d = {6'h00, pin_in};       // [RULE5] [RULE6]
                `TBPM_ADDR_MODE: rdata_d = {4'h0, mode_q};
                default:         rdata_d = 8'h00;
            endcase
        end
    end

    // pump forcing group
    always_comb begin
        pump_en_d  = (pump_mode == TBPM_PUMP_ON);  // [RULE13]
        pump_byp_d = (pump_mode == TBPM_PUMP_OFF); // [RULE12]
        // auto mode: supply-level decision lives in the analog monitor outside
    end

    // reference roles take the same one-edge delay as the pad cells, so the
    // analog path never meets a digital driver that is still on
    always_comb begin
        ref_d = {mode_q[`TBPM_MODE_REFIN], mode_q[`TBPM_MODE_REFOUT]}; // [RULE10] [RULE11]
    end

    // address pins are looked at once, on the first edge after reset;
    // a later change on the pins must not move the bus address
    always_comb begin
        saddr_d      = saddr_q;
        addr_taken_d = 1'b1;
        if (!addr_taken_q) begin
            saddr_d = {fuse_addr, pin_in}; // [RULE14]
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dir_q  <= `TBPM_DIR_RST;  // [RULE4]
            data_q <= `TBPM_DATA_RST; // [RULE9]
            mode_q <= `TBPM_MODE_RST;
        end else begin
            dir_q  <= dir_d;
            data_q <= data_d;
            mode_q <= mode_d;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pump_en_q  <= 1'b0;
            pump_byp_q <= 1'b0;
            ref_q      <= 2'b00;
        end else begin
            pump_en_q  <= pump_en_d;
            pump_byp_q <= pump_byp_d;
            ref_q      <= ref_d;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            saddr_q      <= {`TBPM_FUSE_ADDR_RST, 2'b00};
            addr_taken_q <= 1'b0;
        end else begin
            saddr_q      <= saddr_d;
            addr_taken_q <= addr_taken_d;
        end
    end

    assign pin0.dir     = dir_q[0];
    assign pin0.data    = data_q[0];
    assign pin0.ref_sel = mode_q[`TBPM_MODE_REFOUT]; // [RULE10]
    assign pin1.dir     = dir_q[1];
    assign pin1.data    = data_q[1];
    assign pin1.ref_sel = mode_q[`TBPM_MODE_REFIN];  // [RULE10]

    tbpm_pad u_pad0 (.clk(clk), .rst_n(rst_n), .pin(pin0));
    tbpm_pad u_pad1 (.clk(clk), .rst_n(rst_n), .pin(pin1));

    // pad cells own their flops so these outputs stay register-driven
    assign port_pin_zero_out      = pin0.pad_out;
    assign port_pin_zero_oe_n     = pin0.pad_oe_n;
    assign port_pin_one_out       = pin1.pad_out;
    assign port_pin_one_oe_n      = pin1.pad_oe_n;
    assign reference_drive_out_en = ref_q[0];
    assign reference_take_in_en   = ref_q[1];
    assign pump_enable            = pump_en_q;
    assign pump_bypass_to_battery = pump_byp_q;
    assign slave_addr             = saddr_q;
    assign reg_rdata              = rdata_q;
endmodule

// *** dv/tbpm_port_assertions.sv ***
// concurrent checks on the two-bit port top, bound to its ports
`timescale 1ns/1ps
module tbpm_port_chk (
    input wire logic                 clk,
    input wire logic                 rst_n,
    input wire logic                 reg_wr,
    input wire logic                 reg_rd,
    input wire tbpm_pkg::tbpm_addr_t reg_addr,
    input wire tbpm_pkg::tbpm_byte_t reg_wdata,
    input wire tbpm_pkg::tbpm_byte_t reg_rdata,
    input wire logic                 port_pin_zero_in,
    input wire logic                 port_pin_one_in,
    input wire logic                 port_pin_zero_out,
    input wire logic                 port_pin_zero_oe_n,
    input wire logic                 port_pin_one_out,
    input wire logic                 port_pin_one_oe_n,
    input wire logic                 reference_drive_out_en,
    input wire logic                 reference_take_in_en,
    input wire logic                 pump_enable,
    input wire logic                 pump_bypass_to_battery
);
    import tbpm_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_ref_out_release: assert property (
        reference_drive_out_en |-> port_pin_zero_oe_n && !port_pin_zero_out)
        else $error("pin zero not released in reference role");
    a_ref_in_release: assert property (
        reference_take_in_en |-> port_pin_one_oe_n && !port_pin_one_out)
        else $error("pin one not released in reference role");
    a_pump_on_force: assert property (
        (reg_wr && reg_addr == 8'h70 && reg_wdata[3]) ##1 !(reg_wr && reg_addr == 8'h70)
        |-> ##1 pump_enable && !pump_bypass_to_battery)
        else $error("pump force on not honoured");
    a_pump_off_force: assert property (
        (reg_wr && reg_addr == 8'h70 && reg_wdata[3:2] == 2'b01)
        ##1 !(reg_wr && reg_addr == 8'h70)
        |-> ##1 pump_bypass_to_battery && !pump_enable)
        else $error("pump force off not honoured");
    a_dir_zero_release: assert property (
        (reg_wr && reg_addr == 8'h40 && !reg_wdata[2]) ##1 !(reg_wr && reg_addr == 8'h40)
        |-> ##1 port_pin_zero_oe_n)
        else $error("input-only pin still driven");
    a_data_drive: assert property (
        (reg_wr && reg_addr == 8'h40 && reg_wdata[3]) ##1 !(reg_wr && reg_addr == 8'h40)
        |-> ##1 (reference_take_in_en
                 || (!port_pin_one_oe_n && port_pin_one_out == $past(reg_wdata[1], 2))))
        else $error("pin one does not drive its data bit");
    a_read_in_raw: assert property (
        reg_rd && reg_addr == 8'h41
        |=> reg_rdata == {6'h00, $past(port_pin_one_in), $past(port_pin_zero_in)})
        else $error("input register not raw pin levels");
    a_unmapped_zero: assert property (
        reg_rd && !(reg_addr inside {8'h40, 8'h41, 8'h70}) |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
endmodule
bind tbpm_port tbpm_port_chk i_tbpm_port_chk (.*);

// *** dv/tbpm_sensor.sv ***
// sensor-side circuitry on one port pin
`timescale 1ns/1ps
module tbpm_sensor (
    input  wire logic pad_out,
    input  wire logic pad_oe_n,
    input  wire logic drive,
    output      logic level
);
    // the sensor drives only a pin that the port has released
    assign level = pad_oe_n ? drive : pad_out;
endmodule

// *** dv/tbpm_port_tb.sv ***
// self-checking bench for the two-bit port
`timescale 1ns/1ps
module tbpm_port_tb;
    import tbpm_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
    tbpm_addr_t addr = 8'h00;
    tbpm_byte_t wdata = 8'h00, rdata;
    logic [4:0] fuse = 5'h15;
    logic [6:0] saddr;
    logic [1:0] ext = 2'b00, lvl, po, oen;
    logic ref_o, ref_i, p_on, p_byp;
    integer n_fail = 0, tests_run = 0, seed = 32'h99d9, out_m = 12, mode_m = 0, i, k, e_oe, e_lv;
    always #5 clk = ~clk;
    tbpm_port i_tbpm_port (.clk(clk), .rst_n(rst_n), .reg_wr(wr), .reg_rd(rd), .reg_addr(addr),
        .reg_wdata(wdata), .reg_rdata(rdata), .fuse_addr(fuse), .port_pin_zero_in(lvl[0]),
        .port_pin_one_in(lvl[1]), .port_pin_zero_out(po[0]), .port_pin_zero_oe_n(oen[0]),
        .port_pin_one_out(po[1]), .port_pin_one_oe_n(oen[1]), .reference_drive_out_en(ref_o),
        .reference_take_in_en(ref_i), .pump_enable(p_on), .pump_bypass_to_battery(p_byp),
        .slave_addr(saddr));
    tbpm_sensor i_tbpm_sensor_0 (.pad_out(po[0]), .pad_oe_n(oen[0]), .drive(ext[0]),
        .level(lvl[0]));
    tbpm_sensor i_tbpm_sensor_1 (.pad_out(po[1]), .pad_oe_n(oen[1]), .drive(ext[1]),
        .level(lvl[1]));
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        wr = 1'b1; addr = a; wdata = d;
        @(negedge clk);
        wr = 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] e, input string nm);
        @(negedge clk);
        rd = 1'b1; addr = a;
        @(negedge clk);
        rd = 1'b0;
        chk(nm, rdata, e);
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (100000) @(posedge clk);
        n_fail++;
        print_verdict;
    end
    initial begin
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        chk("slave_addr", {1'b0, saddr}, {1'b0, fuse, lvl});
        chk("pins_after_reset", {4'h0, oen, po}, 8'h00);
        rd_reg(8'h40, 8'h0c, "out_reg_reset");
        for (i = 0; i < 60; i++) begin
            k = $random(seed);
            ext = k[1:0];
            if (k[2]) begin
                wr_reg(8'h40, k[15:8]);
                out_m = k[11:8];
            end
            if (k[3]) begin
                wr_reg(8'h70, k[23:16]);
                mode_m = k[19:16];
            end
            // a write to the read-only input register must change nothing
            wr_reg(8'h41, k[31:24]);
            @(negedge clk);
            e_oe = (~(out_m >> 2) | mode_m) & 3;
            e_lv = ((e_oe & ext) | (~e_oe & out_m)) & 3;
            chk("oe_n", 8'(oen), 8'(e_oe));
            chk("pad_out", 8'(po & ~oen), 8'(~e_oe & out_m & 3));
            chk("ref_roles", {6'h00, ref_i, ref_o}, 8'(mode_m & 3));
            chk("pump", {p_on, p_byp}, {mode_m[3], mode_m[2] & ~mode_m[3]});
            rd_reg(8'h41, 8'(e_lv), "in_reg");
            rd_reg(8'h40, 8'(out_m), "out_reg");
            rd_reg(8'h70, 8'(mode_m), "mode_reg");
            rd_reg(8'h33, 8'h00, "unmapped");
        end
        // second reset mid-run with fresh fuse bits: the address must follow them
        @(negedge clk);
        k = $random(seed);
        fuse = k[4:0];
        ext = k[6:5];
        rst_n = 1'b0;
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        chk("slave_addr_rerun", {1'b0, saddr}, {1'b0, fuse, 2'b00});
        chk("pins_rerun", {4'h0, oen, po}, 8'h00);
        chk("roles_rerun", {4'h0, ref_i, ref_o, p_on, p_byp}, 8'h00);
        rd_reg(8'h70, 8'h00, "mode_reg_reset");
        print_verdict;
    end
endmodule
